// >>> core/ccc_checker.sv
// cell rate conformance checker with axi4-lite register slave
// Summary of operation
// [R01] dual profile: peak instance checks every cell against peak increment and delay tolerance
// [R02] dual profile: sustainable instance checks priority-0 cells, limit burst plus delay tolerance
// [R03] dual profile: priority-0 cell conforms untouched only when both instances pass
// [R04] dual profile: priority-1 cell conforms when peak instance passes
// [R05] dual profile: priority-0 cell failing sustainable but passing peak is tagged, conforming
// [R06] constant-rate profile: only priority-0 cells checked by one peak instance
// [R07] tagged and source-marked cells leave identical; no tag mark travels with the cell
// [R08] source may pre-mark excess cells as priority 1 or leave tagging here
// [R09] unshaped multiplexed traffic is tolerated by tagging rather than rejecting
// [R10] instance state updates only on a conforming evaluation of that instance
// [R11] non-conforming verdict is a classification only; cell still forwarded
// [R12] theoretical arrival time: conform if ta >= tat - limit, then tat = max + inc
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module ccc_checker
  import ccc_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              in_valid,
  output      logic              in_ready,
  input  wire ccc_cell_t         in_cell,
  output      logic              out_valid,
  input  wire logic              out_ready,
  output      ccc_verdict_t      out_cell,
  output      logic              irq
);

  // ==========================================================
  // functions
  function automatic logic gcra_ok(input logic [31:0] ta,
                                   input logic [31:0] tat,
                                   input logic [31:0] lim);
    gcra_ok = (tat <= ta) || ((tat - ta) <= lim); // R12
  endfunction

  function automatic logic [31:0] gcra_next(input logic [31:0] ta,
                                            input logic [31:0] tat,
                                            input logic [31:0] inc);
    gcra_next = ((tat > ta) ? tat : ta) + inc; // R12
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0]  s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    apply_strb = r;
  endfunction

  // ==========================================================
  // registers
  logic [31:0]       ctrl_reg;
  logic [31:0]       peak_inc_reg;
  logic [31:0]       cdv_tol_reg;
  logic [31:0]       sus_inc_reg;
  logic [31:0]       burst_tol_reg;
  logic [INT_W-1:0]  int_stat_reg;
  logic [INT_W-1:0]  int_en_reg;
  logic [CNT_W-1:0]  nc_cnt_reg;
  logic [CNT_W-1:0]  tag_cnt_reg;
  logic [31:0]       time_reg;
  logic [31:0]       pk_tat_reg;
  logic [31:0]       sus_tat_reg;
  logic              out_valid_reg;
  ccc_verdict_t      out_cell_reg;
  logic              aw_have_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic              w_have_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;

  // ==========================================================
  // cell path decode
  wire        en       = ctrl_reg[CTRL_EN_BIT];
  wire        cbr      = ctrl_reg[CTRL_CBR_BIT];
  wire        tag_en   = ctrl_reg[CTRL_TAG_BIT];
  wire        clp      = in_cell.hdr[CLP_BIT];
  wire        fire_in  = in_valid && in_ready;
  wire [31:0] sus_lim  = burst_tol_reg + cdv_tol_reg; // R02
  wire        pk_ok    = gcra_ok(time_reg, pk_tat_reg, cdv_tol_reg); // R01
  wire        sus_ok   = gcra_ok(time_reg, sus_tat_reg, sus_lim); // R02
  // peak covers the aggregate in dual mode, priority 0 only in cbr
  wire        pk_sel   = en && (!cbr || !clp); // R01 R06
  wire        sus_sel  = en && !cbr && !clp; // R02 R06
  wire        pk_upd   = fire_in && pk_sel && pk_ok; // R10
  wire        sus_upd  = fire_in && sus_sel && sus_ok; // R10
  wire [31:0] pk_new   = gcra_next(time_reg, pk_tat_reg, peak_inc_reg);
  wire [31:0] sus_new  = gcra_next(time_reg, sus_tat_reg, sus_inc_reg);
  // tag instead of reject keeps unshaped lan traffic flowing
  wire        tag      = sus_sel && pk_ok && !sus_ok && tag_en; // R05 R09
  wire        conf_dual = clp ? pk_ok : (pk_ok && (sus_ok || tag_en)); // R03 R04
  wire        conf_cbr = !clp && pk_ok; // R06
  wire        conform  = !en || (cbr ? conf_cbr : conf_dual);
  // only the priority bit changes; nothing marks a tagged cell
  wire [31:0] hdr_out  = tag ? (in_cell.hdr | (32'h1 << CLP_BIT)) : in_cell.hdr; // R05 R07
  wire        ev_nc    = fire_in && !conform; // R11
  wire        ev_tag   = fire_in && tag;

  assign in_ready  = !out_valid_reg || out_ready;
  assign out_valid = out_valid_reg;
  assign out_cell  = out_cell_reg;

  // ==========================================================
  // rate instances and output stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      time_reg    <= 32'h0;
      pk_tat_reg  <= 32'h0;
      sus_tat_reg <= 32'h0;
    end else begin
      time_reg <= time_reg + 32'h1;
      if (pk_upd) begin
        pk_tat_reg <= pk_new; // R10 R12
      end
      if (sus_upd) begin
        sus_tat_reg <= sus_new; // R10 R12
      end
    end
  end

  // non-conforming cells still pass; policing is left downstream
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid_reg <= 1'b0;
      out_cell_reg  <= '0;
    end else if (in_ready) begin
      out_valid_reg <= in_valid; // R11
      if (in_valid) begin
        out_cell_reg <= '{hdr: hdr_out, conform: conform};
      end
    end
  end

  // ==========================================================
  // axi4-lite write channel
  wire do_wr    = aw_have_reg && w_have_reg && !bvalid_reg;
  wire wr_ctrl  = do_wr && (aw_addr_reg == OFF_CTRL);
  wire wr_pinc  = do_wr && (aw_addr_reg == OFF_PEAK_INC);
  wire wr_cdv   = do_wr && (aw_addr_reg == OFF_CDV_TOL);
  wire wr_sinc  = do_wr && (aw_addr_reg == OFF_SUS_INC);
  wire wr_bt    = do_wr && (aw_addr_reg == OFF_BURST_TOL);
  wire wr_ien   = do_wr && (aw_addr_reg == OFF_INT_EN);
  wire wr_iclr  = do_wr && (aw_addr_reg == OFF_INT_CLR);
  wire wr_ro    = (aw_addr_reg == OFF_INT_STAT) || (aw_addr_reg == OFF_COUNTS) ||
                  (aw_addr_reg == OFF_TIME);
  wire wr_hit   = wr_ctrl || wr_pinc || wr_cdv || wr_sinc || wr_bt || wr_ien || wr_iclr ||
                  (do_wr && wr_ro);
  wire [31:0] clr_mask = apply_strb(32'h0, w_data_reg, w_strb_reg);
  wire [INT_W-1:0] clr_bits = wr_iclr ? clr_mask[INT_W-1:0] : '0;
  wire [INT_W-1:0] ev_bits  = {ev_tag, ev_nc};
  // a new event wins over a clear in the same cycle
  wire [INT_W-1:0] int_stat_next = (int_stat_reg & ~clr_bits) | ev_bits;
  wire [31:0] ien_word = apply_strb({{(32-INT_W){1'b0}}, int_en_reg}, w_data_reg, w_strb_reg);

  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready  = !w_have_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_have_reg  <= 1'b0;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg      <= CTRL_RST;
      peak_inc_reg  <= PEAK_INC_RST;
      cdv_tol_reg   <= CDV_TOL_RST;
      sus_inc_reg   <= SUS_INC_RST;
      burst_tol_reg <= BURST_TOL_RST;
      int_en_reg    <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= apply_strb(ctrl_reg, w_data_reg, w_strb_reg) & 32'h0000_0007;
      end
      if (wr_pinc) begin
        peak_inc_reg <= apply_strb(peak_inc_reg, w_data_reg, w_strb_reg);
      end
      if (wr_cdv) begin
        cdv_tol_reg <= apply_strb(cdv_tol_reg, w_data_reg, w_strb_reg);
      end
      if (wr_sinc) begin
        sus_inc_reg <= apply_strb(sus_inc_reg, w_data_reg, w_strb_reg);
      end
      if (wr_bt) begin
        burst_tol_reg <= apply_strb(burst_tol_reg, w_data_reg, w_strb_reg);
      end
      if (wr_ien) begin
        int_en_reg <= ien_word[INT_W-1:0];
      end
    end
  end

  // ==========================================================
  // events, counters, interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_stat_reg <= '0;
      nc_cnt_reg   <= '0;
      tag_cnt_reg  <= '0;
    end else begin
      int_stat_reg <= int_stat_next;
      if (ev_nc) begin
        nc_cnt_reg <= nc_cnt_reg + 16'h1;
      end
      if (ev_tag) begin
        tag_cnt_reg <= tag_cnt_reg + 16'h1;
      end
    end
  end

  assign irq = |(int_stat_reg & int_en_reg);

  // ==========================================================
  // axi4-lite read channel
  wire [ADDR_W-1:0] ra = s_axi_araddr;
  wire rd_hit = (ra == OFF_CTRL) || (ra == OFF_PEAK_INC) || (ra == OFF_CDV_TOL) ||
                (ra == OFF_SUS_INC) || (ra == OFF_BURST_TOL) || (ra == OFF_INT_STAT) ||
                (ra == OFF_INT_EN) || (ra == OFF_INT_CLR) || (ra == OFF_COUNTS) ||
                (ra == OFF_TIME);
  wire [31:0] rd_word =
    (ra == OFF_CTRL)      ? ctrl_reg :
    (ra == OFF_PEAK_INC)  ? peak_inc_reg :
    (ra == OFF_CDV_TOL)   ? cdv_tol_reg :
    (ra == OFF_SUS_INC)   ? sus_inc_reg :
    (ra == OFF_BURST_TOL) ? burst_tol_reg :
    (ra == OFF_INT_STAT)  ? {{(32-INT_W){1'b0}}, int_stat_reg} :
    (ra == OFF_INT_EN)    ? {{(32-INT_W){1'b0}}, int_en_reg} :
    (ra == OFF_COUNTS)    ? {tag_cnt_reg, nc_cnt_reg} :
    (ra == OFF_TIME)      ? time_reg : 32'h0;

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_dual_p0_pass;
    fire_in && en && !cbr && !clp && pk_ok && sus_ok;
  endsequence

  sequence s_wr_pair;
    aw_have_reg && w_have_reg && !bvalid_reg;
  endsequence

  a_both_pass_clean: assert property (s_dual_p0_pass |=> out_valid && out_cell.conform && // R03
                                      !out_cell.hdr[CLP_BIT])
    else $error("dual pass lost conform or changed priority");

  a_tag_on_sus_fail: assert property (fire_in && en && !cbr && !clp && pk_ok && !sus_ok && tag_en // R05
                                      |=> out_cell.conform && out_cell.hdr[CLP_BIT])
    else $error("sustainable failure not tagged");

  a_p1_peak_only: assert property (fire_in && en && !cbr && clp |=> // R04
                                   out_cell.conform == $past(pk_ok))
    else $error("priority-1 verdict not from peak");

  a_sus_p1_still: assert property (fire_in && en && clp |=> sus_tat_reg == $past(sus_tat_reg)) // R02
    else $error("sustainable state moved on priority-1 cell");

  a_cbr_no_sus: assert property (en && cbr |=> sus_tat_reg == $past(sus_tat_reg)) // R06
    else $error("sustainable instance active in cbr");

  a_peak_nc_hold: assert property (fire_in && !pk_ok |=> pk_tat_reg == $past(pk_tat_reg)) // R10
    else $error("peak state updated on failure");

  a_peak_advance: assert property (pk_upd |=> pk_tat_reg > $past(time_reg) || // R01
                                   $past(peak_inc_reg) == 32'h0)
    else $error("peak tat not beyond arrival after update");

  a_nc_no_drop: assert property (fire_in && !conform |=> out_valid && !out_cell.conform && // R11
                                 out_cell.hdr == $past(in_cell.hdr))
    else $error("non-conforming cell altered or dropped");

  // a clear in the cycle after the event may drop the bit one cycle later
  a_nc_sticky: assert property (ev_nc |=> int_stat_reg[INT_NC_BIT] ##1 // R11
                                (int_stat_reg[INT_NC_BIT] || $past(wr_iclr)))
    else $error("non-conforming status not held");

  a_write_resp: assert property (s_wr_pair |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response missing");

endmodule

// >>> core/ccc_pkg.sv
// package for the cell rate conformance checker: map, fields, resets, types
package ccc_pkg;

  // ==========================================================
  // register bus
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_PEAK_INC  = 8'h04;
  localparam logic [7:0]  OFF_CDV_TOL   = 8'h08;
  localparam logic [7:0]  OFF_SUS_INC   = 8'h0c;
  localparam logic [7:0]  OFF_BURST_TOL = 8'h10;
  localparam logic [7:0]  OFF_INT_STAT  = 8'h14;
  localparam logic [7:0]  OFF_INT_EN    = 8'h18;
  localparam logic [7:0]  OFF_INT_CLR   = 8'h1c;
  localparam logic [7:0]  OFF_COUNTS    = 8'h20;
  localparam logic [7:0]  OFF_TIME      = 8'h24;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ==========================================================
  // fields
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_CBR_BIT  = 1;
  localparam int          CTRL_TAG_BIT  = 2;
  localparam int          INT_NC_BIT    = 0;
  localparam int          INT_TAG_BIT   = 1;
  localparam int          INT_W         = 2;
  localparam int          CNT_W         = 16;
  localparam int          CLP_BIT       = 0;

  // ==========================================================
  // reset values
  localparam logic [31:0] CTRL_RST      = 32'h0000_0005;
  localparam logic [31:0] PEAK_INC_RST  = 32'h0000_0004;
  localparam logic [31:0] CDV_TOL_RST   = 32'h0000_0002;
  localparam logic [31:0] SUS_INC_RST   = 32'h0000_0010;
  localparam logic [31:0] BURST_TOL_RST = 32'h0000_0020;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [31:0] hdr;
  } ccc_cell_t;

  typedef struct packed {
    logic [31:0] hdr;
    logic        conform;
  } ccc_verdict_t;

endpackage

// >>> tb/ccc_cell_source.sv
// partner model: user-side cell source feeding the checker
`timescale 1ns/1ps
module ccc_cell_source
  import ccc_pkg::*;
(
  input  wire logic      aclk,
  input  wire logic      in_ready,
  output      logic      in_valid,
  output      ccc_cell_t in_cell
);
  // ==========================================================
  // offer held until taken
  initial begin
    in_valid = 1'b0;
    in_cell  = '0;
  end
  // excess cells may arrive pre-marked priority 1 or left at 0
  task automatic send(input logic [31:0] h);
    in_valid     <= 1'b1;
    in_cell.hdr  <= h;
    @(posedge aclk);
    while (!in_ready) @(posedge aclk);
  endtask
  // released bus shows inverted data so a stale header never passes
  task automatic idle();
    in_valid    <= 1'b0;
    in_cell.hdr <= ~in_cell.hdr;
  endtask
endmodule

// >>> tb/ccc_checker_test.sv
// self-checking bench for the cell rate conformance checker
`timescale 1ns/1ps
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", nm, e, a); end end
module ccc_checker_test
  import ccc_pkg::*;
;
  // ==========================================================
  // signals
  logic               aclk, aresetn, in_valid, in_ready, out_valid, out_ready, irq;
  logic [7:0]         s_axi_awaddr, s_axi_araddr;
  logic [31:0]        s_axi_wdata, s_axi_rdata;
  logic [3:0]         s_axi_wstrb;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic               s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  ccc_cell_t          in_cell;
  ccc_verdict_t       out_cell;
  ccc_verdict_t       exp_q[$];
  int                 compares, miscompares, cycles;
  integer             seed = 32'he958;
  logic [31:0]        tb_time, tat_p, tat_s, ctrl_m, pk_m, cdv_m, sus_m, bt_m;
  logic [15:0]        nc_m, tg_m;
  logic [1:0]         st_m;
  ccc_checker u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .in_valid(in_valid), .in_ready(in_ready), .in_cell(in_cell),
    .out_valid(out_valid), .out_ready(out_ready), .out_cell(out_cell), .irq(irq));
  ccc_cell_source u_src (.aclk(aclk), .in_ready(in_ready), .in_valid(in_valid), .in_cell(in_cell));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // ==========================================================
  // reference model, noted at the accepting edge
  function automatic logic fits(input logic [31:0] tat, input logic [31:0] ta, input logic [31:0] lim);
    return (tat <= ta) || (tat - ta <= lim);
  endfunction
  function automatic logic [31:0] adv(input logic [31:0] tat, input logic [31:0] ta, input logic [31:0] inc);
    return ((ta > tat) ? ta : tat) + inc;
  endfunction
  always @(posedge aclk) begin : model
    ccc_verdict_t v;
    logic         pk, su, c0;
    if (!aresetn) begin
      tb_time <= '0;
      tat_p = '0;
      tat_s = '0;
      nc_m = '0;
      tg_m = '0;
      st_m = '0;
      ctrl_m = CTRL_RST;
      pk_m = PEAK_INC_RST;
      cdv_m = CDV_TOL_RST;
      sus_m = SUS_INC_RST;
      bt_m = BURST_TOL_RST;
    end else begin
      tb_time <= tb_time + 1;
      if (in_valid && in_ready) begin
        v.hdr = in_cell.hdr;
        c0 = !in_cell.hdr[CLP_BIT];
        pk = fits(tat_p, tb_time, cdv_m);
        su = fits(tat_s, tb_time, bt_m + cdv_m);
        v.conform = 1'b1;
        if (ctrl_m[CTRL_EN_BIT] && ctrl_m[CTRL_CBR_BIT]) begin
          v.conform = c0 && pk;
          if (v.conform) tat_p = adv(tat_p, tb_time, pk_m);
        end else if (ctrl_m[CTRL_EN_BIT]) begin
          if (pk) tat_p = adv(tat_p, tb_time, pk_m);
          if (c0 && su) tat_s = adv(tat_s, tb_time, sus_m);
          v.conform = pk && (!c0 || su || ctrl_m[CTRL_TAG_BIT]);
          if (c0 && pk && !su && ctrl_m[CTRL_TAG_BIT]) begin
            v.hdr[CLP_BIT] = 1'b1;
            tg_m++;
            st_m[INT_TAG_BIT] = 1'b1;
          end
        end
        if (!v.conform) begin
          nc_m++;
          st_m[INT_NC_BIT] = 1'b1;
        end
        exp_q.push_back(v);
      end
    end
  end
  // ==========================================================
  // output watcher and stall maker
  always @(posedge aclk) begin : mon
    ccc_verdict_t e;
    if (aresetn && out_valid && out_ready) begin
      e = exp_q.pop_front();
      `CHK("cell", e, out_cell)
    end
  end
  always @(posedge aclk) begin : stall
    integer r;
    r = $random(seed);
    out_ready <= (r[1:0] != 2'h0);
  end
  always @(posedge aclk) begin : dog
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      $display("BAD watchdog exp done got hang");
      final_report();
    end
  end
  // ==========================================================
  // bus tasks
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'b0;
    `CHK("rdata", e, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask
  // ==========================================================
  // cell phases: random headers, optional gaps, drained at the end
  task automatic phase(input logic [31:0] ctrl, input int n, input bit gaps, input bit c0, input string nm);
    integer r;
    axw(OFF_CTRL, ctrl, RESP_OKAY);
    ctrl_m = ctrl;
    @(posedge aclk);
    repeat (n) begin
      r = $random(seed);
      u_src.send(c0 ? {r[31:1], 1'b0} : r);
      if (gaps && r[12]) begin
        u_src.idle();
        repeat (r[9:8] + 1) @(posedge aclk);
      end
    end
    u_src.idle();
    // one edge so the last accepted cell is noted before the queue is polled
    @(posedge aclk);
    while (exp_q.size() != 0 || out_valid) @(posedge aclk);
    $display("test %s done", nm);
  endtask
  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin : main
    logic [31:0] rst_v[9];
    logic [31:0] rate_v[4];
    int          i;
    rst_v = '{CTRL_RST, PEAK_INC_RST, CDV_TOL_RST, SUS_INC_RST, BURST_TOL_RST, 0, 0, 0, 0};
    rate_v = '{32'h3, 32'h1, 32'h8, 32'h6};
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    aresetn = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 9; i++) axr(8'(i * 4), rst_v[i], RESP_OKAY);
    axr(8'h28, 32'h0, RESP_SLVERR);
    axw(8'h28, 32'h1, RESP_SLVERR);
    for (i = 0; i < 4; i++) axw(OFF_PEAK_INC + 8'(i * 4), rate_v[i], RESP_OKAY);
    {pk_m, cdv_m, sus_m, bt_m} = {rate_v[0], rate_v[1], rate_v[2], rate_v[3]};
    axw(OFF_INT_EN, 32'h3, RESP_OKAY);
    phase(32'h5, 40, 1'b0, 1'b1, "burst");
    `CHK("irq", |st_m, irq)
    axr(OFF_INT_STAT, {30'h0, st_m}, RESP_OKAY);
    axw(OFF_INT_CLR, 32'h3, RESP_OKAY);
    st_m = '0;
    `CHK("irq_clr", 1'b0, irq)
    phase(32'h5, 150, 1'b1, 1'b0, "dual");
    phase(32'h1, 100, 1'b1, 1'b0, "notag");
    axw(OFF_INT_EN, 32'h0, RESP_OKAY);
    `CHK("irq_mask", 1'b0, irq)
    phase(32'h3, 100, 1'b1, 1'b0, "cbr");
    phase(32'h0, 40, 1'b0, 1'b0, "off");
    axr(OFF_COUNTS, {tg_m, nc_m}, RESP_OKAY);
    axr(OFF_INT_STAT, {30'h0, st_m}, RESP_OKAY);
    final_report();
  end
endmodule
